/* rtl/qmm_mem_if.sv */
/*
 * byte access path from the two-wire engine to the memory map.
 * assumes both ends run on sys_clk; rdata is combinational from addr.
 */
`timescale 1ns/1ps
interface qmm_mem_if;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       we;
	logic       re;
	modport master (output addr, output wdata, output we, output re, input rdata);
	modport target (input addr, input wdata, input we, input re, output rdata);
endinterface

/* rtl/qmm_pkg.sv */
/*
 * constants for the pluggable-module management block: timing counts,
 * memory map offsets, field positions and reset values.
 * assumes a 40 MHz system clock inside the module.
 */
// Notes on behaviour
// RL1: seven low-speed pins: select, two-wire, reset, power, present, alert
// RL2: answer two-wire traffic only while select is low
// RL3: host gives every module its own select line
// RL4: two-wire transactions read and write the memory map
// RL5: reset low beyond minimum restores all defaults
// RL6: host ignores status bits while reset executes
// RL7: reset completion raises alert with pending flag clear
// RL8: power-up posts completion alert without reset pulse
// RL9: low-power pin limits module power draw
// RL10: module pulls presence line low when inserted
// RL11: alert line low flags fault or critical status
// RL12: host reads cause of alert over two-wire bus
// RL13: lanes addressable; host-marked unused lanes shut down
// RL14: pending flag set from reset until initialisation ends
// RL15: alert held until host reads causing flag
package qmm_pkg;

	// =====================================================
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int RST_MIN_NS    = 10000;
	localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_NS       = 20000;
	localparam int INIT_CYC      = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 10;
	localparam logic [CNT_W-1:0] RST_MIN_CNT = CNT_W'(RST_MIN_CYC);
	localparam logic [CNT_W-1:0] INIT_LAST   = CNT_W'(INIT_CYC - 1);

	// =====================================================
	// two-wire bus and memory map
	localparam logic [6:0] DEV_ADDR     = 7'h50;
	localparam int         LANES        = 4;
	localparam logic [3:0] ADR_ID       = 4'h0;
	localparam logic [3:0] ADR_STATUS   = 4'h1;
	localparam logic [3:0] ADR_FLAGS    = 4'h2;
	localparam logic [3:0] ADR_LANE_DIS = 4'h3;
	localparam logic [3:0] ADR_CTRL     = 4'h4;
	localparam int         PEND_BIT     = 0;
	localparam int         FLAG_DONE    = 0;
	localparam int         FLAG_LPM     = 1;
	localparam int         CTRL_LOWPWR  = 0;
	// arbitrary identifier value
	localparam logic [7:0] ID_VALUE     = 8'h5A;
	localparam logic [3:0] LANE_DIS_RST = 4'h0;
	localparam logic       CTRL_RST     = 1'b0;

endpackage

/* rtl/qmm_top.sv */
/*
 * management side of a pluggable four-lane module: pin synchronisers,
 * module reset sequencer, memory map and alert/presence/power/lane outputs.
 * assumes host pins are asynchronous and open-drain wires are resolved
 * outside from the enables.
 */
`timescale 1ns/1ps
module qmm_top
	import qmm_pkg::*;
(
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	// host control pins
	input  wire logic             module_select_n,
	input  wire logic             module_reset_n,
	input  wire logic             low_power_select,
	// two-wire bus
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	output logic                  sda_out,
	output logic                  sda_oe,
	// status pins
	output logic                  presence_detect_n,
	output logic                  fault_alert_n_out,
	output logic                  fault_alert_oe,
	// module-side controls
	output logic                  high_power_en,
	output logic [LANES-1:0]      tx_lane_en
);

	typedef enum logic [1:0] {
		RS_INIT  = 2'b00,
		RS_RUN   = 2'b01,
		RS_HOLD  = 2'b11,
		RS_RESET = 2'b10
	} qmm_rst_e;

	localparam int INIT_BOUND = INIT_CYC + 4;

	// =====================================================
	// pin synchronisers, [0] read only by [1]
	logic [1:0]       rstn_sync;
	logic [1:0]       sel_sync;
	logic [1:0]       lp_sync;
	qmm_rst_e         st_reg, st_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [1:0]       flags_reg, flags_next;
	logic [1:0]       flag_set, flag_clr;
	logic [3:0]       lane_dis_reg, lane_dis_next;
	logic             ctrl_reg, ctrl_next;
	logic             lp_d_reg;
	logic             pend_reg, pend_next;
	logic             alert_reg, alert_next;
	logic             hpe_reg, hpe_next;
	logic [3:0]       lane_en_reg, lane_en_next;
	logic             low_reg;
	logic             twi_rst;
	logic             flag_read;
	logic [CNT_W:0]   low_run_reg, low_run_next;

	qmm_mem_if mem_bus ();

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rstn_sync <= 2'h3;
			sel_sync  <= 2'h3;
			lp_sync   <= 2'h3;
		end
		else
		begin
			rstn_sync <= {rstn_sync[0], module_reset_n};
			sel_sync  <= {sel_sync[0], module_select_n};
			lp_sync   <= {lp_sync[0], low_power_select};
		end
	end

	// =====================================================
	// two-wire engine; held in reset with the rest of the module
	// a transfer cut by a module reset restarts cleanly at the next start
	assign twi_rst = sys_rst | (st_reg == RS_RESET);

	qmm_twi_slave qmm_twi_slave_i (
		.sys_clk (sys_clk),
		.sys_rst (twi_rst),
		.sel_n   (sel_sync[1]),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.sda_oe  (sda_oe),
		.mem     (mem_bus.master)
	);

	// =====================================================
	// memory map read side; unmapped bytes read zero
	function automatic logic [7:0] map_read(
		input logic [3:0] a,
		input logic       pend,
		input logic [1:0] flags,
		input logic [3:0] dis,
		input logic       ctrl
	);
		case (a)
			ADR_ID:       map_read = ID_VALUE;
			ADR_STATUS:   map_read = {7'h00, pend};
			ADR_FLAGS:    map_read = {6'h00, flags};
			ADR_LANE_DIS: map_read = {4'h0, dis};
			ADR_CTRL:     map_read = {7'h00, ctrl};
			default:      map_read = 8'h00;
		endcase
	endfunction

	// one map byte hit by a strobe; shared by the writes and the clear-on-read
	function automatic logic map_hit(
		input logic       strobe,
		input logic [3:0] a,
		input logic [3:0] target
	);
		map_hit = strobe && (a == target);
	endfunction

	assign mem_bus.rdata = map_read(mem_bus.addr, pend_reg, flags_reg, lane_dis_reg, ctrl_reg); // RL4
	// the flags byte clears when loaded for transmit, not when the host acks it
	assign flag_read     = map_hit(mem_bus.re, mem_bus.addr, ADR_FLAGS);

	// =====================================================
	// reset sequencer and map registers
	always_comb
	begin
		st_next       = st_reg;
		cnt_next      = cnt_reg;
		lane_dis_next = lane_dis_reg;
		ctrl_next     = ctrl_reg;
		flag_set      = 2'h0;
		flag_clr      = flag_read ? flags_reg : 2'h0; // RL15
		case (st_reg)
			RS_RUN:
				if (!rstn_sync[1])
				begin
					st_next  = RS_HOLD;
					cnt_next = {{(CNT_W-1){1'b0}}, 1'b1};
				end
			// short pulses are ignored; only a low beyond the minimum resets
			RS_HOLD:
				if (rstn_sync[1])
					st_next = RS_RUN;
				else if (cnt_reg == RST_MIN_CNT)
					st_next = RS_RESET; // RL5
				else
					cnt_next = cnt_reg + 1'b1;
			RS_RESET:
				if (rstn_sync[1])
				begin
					st_next  = RS_INIT;
					cnt_next = '0;
				end
			RS_INIT:
				if (cnt_reg == INIT_LAST)
				begin
					st_next             = RS_RUN;
					flag_set[FLAG_DONE] = 1'b1; // RL7
				end
				else
					cnt_next = cnt_reg + 1'b1;
			default:
				st_next = RS_INIT;
		endcase
		if (map_hit(mem_bus.we, mem_bus.addr, ADR_LANE_DIS))
			lane_dis_next = mem_bus.wdata[LANES-1:0]; // RL13
		if (map_hit(mem_bus.we, mem_bus.addr, ADR_CTRL))
			ctrl_next = mem_bus.wdata[CTRL_LOWPWR];
		// not flagged during initialisation: the synchroniser fills from its
		// reset level then, and would otherwise raise a false event
		if (st_reg != RS_INIT && lp_sync[1] != lp_d_reg)
			flag_set[FLAG_LPM] = 1'b1;
		// a new event in the cycle of its read is kept
		flags_next = (flags_reg & ~flag_clr) | flag_set;
		if (st_reg == RS_RESET)
		begin
			lane_dis_next = LANE_DIS_RST; // RL5
			ctrl_next     = CTRL_RST;
			flags_next    = 2'h0;
		end
		// a low below the minimum leaves status and lanes untouched
		pend_next    = (st_next == RS_RESET) || (st_next == RS_INIT); // RL14
		alert_next   = |flags_next; // RL11
		hpe_next     = ~lp_sync[1] & ~ctrl_next; // RL9
		lane_en_next = pend_next ? 4'h0 : ~lane_dis_next; // RL13
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			st_reg       <= RS_INIT; // RL8
			cnt_reg      <= '0;
			flags_reg    <= 2'h0;
			lane_dis_reg <= LANE_DIS_RST;
			ctrl_reg     <= CTRL_RST;
			lp_d_reg     <= 1'b1;
			pend_reg     <= 1'b1;
			alert_reg    <= 1'b0;
			hpe_reg      <= 1'b0;
			lane_en_reg  <= 4'h0;
			low_reg      <= 1'b0;
		end
		else
		begin
			st_reg       <= st_next;
			cnt_reg      <= cnt_next;
			flags_reg    <= flags_next;
			lane_dis_reg <= lane_dis_next;
			ctrl_reg     <= ctrl_next;
			lp_d_reg     <= lp_sync[1];
			pend_reg     <= pend_next;
			alert_reg    <= alert_next;
			hpe_reg      <= hpe_next;
			lane_en_reg  <= lane_en_next;
			low_reg      <= 1'b0;
		end
	end

	// =====================================================
	// pins; open-drain lines only ever pull low
	assign presence_detect_n = low_reg; // RL10
	assign sda_out           = low_reg; // RL1
	assign fault_alert_n_out = low_reg; // RL1
	assign fault_alert_oe    = alert_reg; // RL11
	assign high_power_en     = hpe_reg;
	assign tx_lane_en        = lane_en_reg;

	// =====================================================
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	// run length of the present low on the reset pin; saturates at the top bit
	always_comb
	begin
		low_run_next = low_run_reg;
		if (rstn_sync[1])
			low_run_next = '0;
		else if (!low_run_reg[CNT_W])
			low_run_next = low_run_reg + 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			low_run_reg <= '0;
		else
			low_run_reg <= low_run_next;
	end

	presence_low_a: assert property (!presence_detect_n && !fault_alert_n_out) // RL10
		else $error("presence or alert level not low");
	reset_min_a: assert property ($rose(st_reg == RS_RESET) |-> low_run_reg > RST_MIN_CYC) // RL5
		else $error("reset taken before minimum low time");
	short_pulse_a: assert property (st_reg == RS_HOLD && rstn_sync[1] |=> st_reg == RS_RUN) // RL5
		else $error("short reset pulse not ignored");
	defaults_a: assert property (st_reg == RS_RESET |=> // RL5
		lane_dis_reg == LANE_DIS_RST && ctrl_reg == CTRL_RST && flags_reg == 2'h0)
		else $error("settings not back to defaults");
	pending_a: assert property ((st_reg == RS_RESET || st_reg == RS_INIT) |-> // RL14
		pend_reg && !(|tx_lane_en))
		else $error("pending flag clear during reset");
	done_alert_a: assert property ($fell(pend_reg) |-> fault_alert_oe && flags_reg[FLAG_DONE]) // RL7
		else $error("reset done without alert");
	powerup_a: assert property ($fell(sys_rst) |-> ##[1:INIT_BOUND] (fault_alert_oe && !pend_reg)) // RL8
		else $error("no completion alert after power-up");
	alert_hold_a: assert property (fault_alert_oe && !flag_read && st_reg != RS_RESET // RL15
		|=> fault_alert_oe)
		else $error("alert dropped before flag read");
	power_a: assert property ((lp_sync[1] || ctrl_reg) ##1 (lp_sync[1] || ctrl_reg) // RL9
		|-> !high_power_en)
		else $error("high power while limited");
	lanes_a: assert property (st_reg == RS_RUN && lane_dis_reg[0] |-> !tx_lane_en[0]) // RL13
		else $error("disabled lane left on");
	lanes_all_a: assert property (st_reg == RS_RUN |-> tx_lane_en == ~lane_dis_reg) // RL13
		else $error("lane enables differ from disable byte");
	hold_quiet_a: assert property (st_reg == RS_HOLD |-> // RL5
		!pend_reg && tx_lane_en == ~lane_dis_reg)
		else $error("short reset low disturbed the module");
	reset_stay_a: assert property (st_reg == RS_RESET && !rstn_sync[1] |=> // RL5
		st_reg == RS_RESET)
		else $error("reset left while pin still low");
	init_end_a: assert property (st_reg == RS_INIT && cnt_reg == INIT_LAST |=> // RL14
		st_reg == RS_RUN && !pend_reg)
		else $error("initialisation did not end on time");
	init_quiet_a: assert property (st_reg == RS_INIT && !flags_reg[FLAG_LPM] |=> // RL11
		!flags_reg[FLAG_LPM])
		else $error("power pin event raised during initialisation");
	lpm_flag_a: assert property (st_reg == RS_RUN && lp_sync[1] != lp_d_reg |=> // RL11
		flags_reg[FLAG_LPM])
		else $error("power pin change not flagged");
	read_clear_a: assert property (flag_read && st_reg == RS_RUN && // RL15
		lp_sync[1] == lp_d_reg |=> flags_reg == 2'h0)
		else $error("flags not cleared by read");
	hpe_on_a: assert property ((!lp_sync[1] && !ctrl_reg) ##1 (!lp_sync[1] && !ctrl_reg) // RL9
		|-> high_power_en)
		else $error("power limited without a request");

	reset_seen_c: cover property ($rose(st_reg == RS_RESET) ##[1:1000] $fell(pend_reg));
	short_pulse_c: cover property (st_reg == RS_HOLD ##1 st_reg == RS_RUN);
	flag_read_c: cover property (fault_alert_oe && flag_read ##1 !fault_alert_oe);
	lane_write_c: cover property (mem_bus.we && mem_bus.addr == ADR_LANE_DIS);
	lpm_event_c: cover property ($rose(flags_reg[FLAG_LPM]));

endmodule // qmm_top

/* rtl/qmm_twi_slave.sv */
/*
 * two-wire serial target: address match, pointer byte, auto-increment
 * reads and writes. assumes sel_n is already synchronised; scl and sda
 * are raw pins and are synchronised here. never stretches the clock.
 */
`timescale 1ns/1ps
module qmm_twi_slave
	import qmm_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// select, synchronised
	input  wire logic sel_n,
	// bus pins
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_oe,
	// memory map access
	qmm_mem_if.master mem
);

	typedef enum logic [2:0] {
		TW_IDLE  = 3'b000,
		TW_ADDR  = 3'b001,
		TW_AACK  = 3'b011,
		TW_WBYTE = 3'b010,
		TW_WACK  = 3'b110,
		TW_RBYTE = 3'b111,
		TW_RACK  = 3'b101
	} qmm_twi_e;

	// =====================================================
	// pin synchronisers: [0] first stage, [1] second, [2] previous
	logic [2:0] scl_reg;
	logic [2:0] sda_reg;
	qmm_twi_e   st_reg, st_next;
	logic [3:0] bit_reg, bit_next;
	logic [3:0] ptr_reg, ptr_next;
	logic [7:0] sh_reg, sh_next;
	logic       rw_reg, rw_next;
	logic       first_reg, first_next;
	logic       oe_reg, oe_next;
	logic       rise, fall, start, stop, load;
	logic [7:0] rx;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			scl_reg <= 3'h7;
			sda_reg <= 3'h7;
		end
		else
		begin
			scl_reg <= {scl_reg[1:0], scl_in};
			sda_reg <= {sda_reg[1:0], sda_in};
		end
	end

	assign rise     = scl_reg[1] & ~scl_reg[2];
	assign fall     = ~scl_reg[1] & scl_reg[2];
	assign start    = scl_reg[1] & scl_reg[2] & sda_reg[2] & ~sda_reg[1];
	assign stop     = scl_reg[1] & scl_reg[2] & ~sda_reg[2] & sda_reg[1];
	assign rx       = {sh_reg[6:0], sda_reg[1]};
	assign mem.addr = ptr_reg;
	assign sda_oe   = oe_reg;

	// =====================================================
	// bit engine
	always_comb
	begin
		st_next    = st_reg;
		bit_next   = bit_reg;
		ptr_next   = ptr_reg;
		sh_next    = sh_reg;
		rw_next    = rw_reg;
		first_next = first_reg;
		oe_next    = oe_reg;
		load       = 1'b0;
		mem.we     = 1'b0;
		mem.re     = 1'b0;
		mem.wdata  = rx;
		if (sel_n)
		begin
			st_next = TW_IDLE; // RL2
			oe_next = 1'b0;
		end
		else if (start)
		begin
			st_next  = TW_ADDR;
			bit_next = 4'h0;
			oe_next  = 1'b0;
		end
		else if (stop)
		begin
			st_next = TW_IDLE;
			oe_next = 1'b0;
		end
		else
		begin
			case (st_reg)
				TW_ADDR:
					if (rise)
					begin
						sh_next  = rx;
						bit_next = bit_reg + 4'h1;
						if (bit_reg == 4'h7)
						begin
							rw_next = sda_reg[1];
							st_next = (rx[7:1] == DEV_ADDR) ? TW_AACK : TW_IDLE;
						end
					end
				TW_AACK:
					if (fall)
					begin
						oe_next    = ~oe_reg;
						first_next = 1'b1;
						bit_next   = 4'h0;
						if (oe_reg && !rw_reg)
							st_next = TW_WBYTE;
						load = oe_reg && rw_reg;
					end
				TW_WBYTE:
					if (rise)
					begin
						sh_next  = rx;
						bit_next = bit_reg + 4'h1;
						if (bit_reg == 4'h7)
						begin
							st_next    = TW_WACK;
							first_next = 1'b0;
							// first byte after the address sets the pointer
							if (first_reg)
								ptr_next = rx[3:0];
							else
							begin
								mem.we   = 1'b1; // RL4
								ptr_next = ptr_reg + 4'h1;
							end
						end
					end
				TW_WACK:
					if (fall)
					begin
						oe_next  = ~oe_reg;
						bit_next = 4'h0;
						if (oe_reg)
							st_next = TW_WBYTE;
					end
				TW_RBYTE:
					if (fall)
					begin
						if (bit_reg == 4'h7)
						begin
							oe_next = 1'b0;
							st_next = TW_RACK;
						end
						else
						begin
							sh_next  = {sh_reg[6:0], 1'b0};
							oe_next  = ~sh_reg[6];
							bit_next = bit_reg + 4'h1;
						end
					end
				TW_RACK:
					if (rise)
					begin
						if (sda_reg[1])
							st_next = TW_IDLE;
						else
							bit_next = 4'h8;
					end
					else if (fall && bit_reg == 4'h8)
						load = 1'b1;
				default:
					st_next = TW_IDLE;
			endcase
		end
		// read load presents bit 7 in the same low phase; the pointer moves on
		if (load)
		begin
			sh_next  = mem.rdata;
			oe_next  = ~mem.rdata[7];
			mem.re   = 1'b1; // RL4
			ptr_next = ptr_reg + 4'h1;
			bit_next = 4'h0;
			st_next  = TW_RBYTE;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			st_reg    <= TW_IDLE;
			bit_reg   <= 4'h0;
			ptr_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			rw_reg    <= 1'b0;
			first_reg <= 1'b0;
			oe_reg    <= 1'b0;
		end
		else
		begin
			st_reg    <= st_next;
			bit_reg   <= bit_next;
			ptr_reg   <= ptr_next;
			sh_reg    <= sh_next;
			rw_reg    <= rw_next;
			first_reg <= first_next;
			oe_reg    <= oe_next;
		end
	end

	// =====================================================
	// checks
	desel_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL2
		sel_n |=> !sda_oe && st_reg == TW_IDLE)
		else $error("bus driven while deselected");
	desel_nowrite_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL2
		sel_n |-> !mem.we && !mem.re)
		else $error("map access while deselected");

endmodule // qmm_twi_slave

/* verification/qmm_host_model.sv */
/*
 * host board model: pull-ups on the two-wire data and alert wires and a
 * bit-level two-wire master. assumes sys_clk from the bench; every scl
 * phase of a data bit spans four sys_clk cycles, a start's high phase eight, and all drives change at negedge.
 */
`timescale 1ns/1ps
module qmm_host_model
	import qmm_pkg::*;
(
	// clock
	input  wire logic sys_clk,
	// module drives
	input  wire logic sda_oe,
	input  wire logic fault_alert_oe,
	// resolved wires
	output logic      scl_in,
	output wire logic sda_in,
	output wire logic fault_alert_n
);
	logic sda_low;

	// =====================================================
	// wires: a released line reads the pull-up, never its last value
	assign sda_in        = !(sda_low || sda_oe);
	assign fault_alert_n = !fault_alert_oe;

	initial
	begin
		scl_in  = 1'b1;
		sda_low = 1'b0;
	end

	// =====================================================
	// bit and byte level
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// data moves one cycle after scl falls so the synchroniser never sees both at once
	task automatic clk_bit(input logic drv, output logic seen);
		tick(1);
		sda_low = !drv;
		tick(3);
		scl_in = 1'b1;
		tick(2);
		seen = sda_in;
		tick(2);
		scl_in = 1'b0;
	endtask

	task automatic start_cond();
		tick(1);
		sda_low = 1'b0;
		tick(3);
		scl_in = 1'b1;
		tick(4);
		sda_low = 1'b1;
		tick(4);
		scl_in = 1'b0;
	endtask

	// scl stays high after the stop until the next frame
	task automatic stop_cond();
		tick(1);
		sda_low = 1'b1;
		tick(3);
		scl_in = 1'b1;
		tick(4);
		sda_low = 1'b0;
		tick(4);
	endtask

	task automatic send_byte(input logic [7:0] d, inout logic ok);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ok = ok && (s === 1'b0);
	endtask

	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(last, s);
	endtask

	// =====================================================
	// map accesses
	task automatic write_byte(input logic [3:0] a, input logic [7:0] v, output logic ok);
		ok = 1'b1;
		start_cond();
		send_byte({DEV_ADDR, 1'b0}, ok);
		send_byte({4'h0, a}, ok);
		send_byte(v, ok);
		stop_cond();
	endtask

	task automatic read_byte(input logic [3:0] a, output logic [7:0] v, output logic ok);
		ok = 1'b1;
		start_cond();
		send_byte({DEV_ADDR, 1'b0}, ok);
		send_byte({4'h0, a}, ok);
		start_cond();
		send_byte({DEV_ADDR, 1'b1}, ok);
		recv_byte(1'b1, v);
		stop_cond();
	endtask
endmodule // qmm_host_model

/* verification/qmm_top_bench.sv */
/*
 * self-checking bench for the module management block.
 * assumes the host model resolves the open-drain wires from the enables.
 */
`timescale 1ns/1ps
module qmm_top_bench
	import qmm_pkg::*;
;
	logic             sys_clk;
	logic             sys_rst;
	logic             module_select_n;
	logic             module_reset_n;
	logic             low_power_select;
	logic             scl_in;
	logic             sda_in;
	logic             sda_out;
	logic             sda_oe;
	logic             presence_detect_n;
	logic             fault_alert_n_out;
	logic             fault_alert_oe;
	logic             fault_alert_n;
	logic             high_power_en;
	logic [LANES-1:0] tx_lane_en;
	logic [7:0]       rdat;
	logic             ok;
	int               err_total = 0;
	int               compares  = 0;
	int               cycles    = 0;

	qmm_top qmm_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.module_select_n(module_select_n), .module_reset_n(module_reset_n),
		.low_power_select(low_power_select), .scl_in(scl_in), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .presence_detect_n(presence_detect_n),
		.fault_alert_n_out(fault_alert_n_out), .fault_alert_oe(fault_alert_oe),
		.high_power_en(high_power_en), .tx_lane_en(tx_lane_en));

	qmm_host_model qmm_host_model_i (.sys_clk(sys_clk), .sda_oe(sda_oe),
		.fault_alert_oe(fault_alert_oe), .scl_in(scl_in), .sda_in(sda_in),
		.fault_alert_n(fault_alert_n));

	// =====================================================
	// clock, timeout, reporting
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic print_verdict();
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// whole run is about 7k cycles; nearly three times that means a hang
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			print_verdict();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			err_total++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic wait_alert(input int limit);
		int n;
		n = 0;
		while (fault_alert_n !== 1'b0 && n < limit)
		begin
			tick(1);
			n++;
		end
		check({7'h0, fault_alert_n}, 8'h00);
	endtask

	// =====================================================
	// scenarios
	task automatic t_boot();
		tick(10);
		check({7'h0, presence_detect_n}, 8'h00);
		check({6'h0, sda_out, fault_alert_n_out}, 8'h00);
		check({7'h0, fault_alert_n}, 8'h01);
		qmm_host_model_i.read_byte(ADR_STATUS, rdat, ok);
		check({7'h0, ok}, 8'h01);
		check({7'h0, rdat[PEND_BIT]}, 8'h01);
		wait_alert(900);
		check({4'h0, tx_lane_en}, 8'h0F);
		qmm_host_model_i.read_byte(ADR_STATUS, rdat, ok);
		check(rdat, 8'h00);
		qmm_host_model_i.read_byte(ADR_ID, rdat, ok);
		check(rdat, ID_VALUE);
		qmm_host_model_i.read_byte(ADR_FLAGS, rdat, ok);
		check(rdat, 8'h01);
		tick(4);
		check({7'h0, fault_alert_n}, 8'h01);
	endtask

	task automatic t_lanes();
		qmm_host_model_i.write_byte(ADR_LANE_DIS, 8'h0F, ok);
		tick(4);
		check({3'h0, ok, tx_lane_en}, 8'h10);
		qmm_host_model_i.write_byte(ADR_LANE_DIS, 8'h05, ok);
		tick(4);
		check({4'h0, tx_lane_en}, 8'h0A);
		qmm_host_model_i.read_byte(ADR_LANE_DIS, rdat, ok);
		check(rdat, 8'h05);
	endtask

	task automatic t_select();
		module_select_n = 1'b1;
		tick(4);
		qmm_host_model_i.write_byte(ADR_LANE_DIS, 8'h0F, ok);
		tick(4);
		check({3'h0, ok, tx_lane_en}, 8'h0A);
		module_select_n = 1'b0;
		tick(4);
		qmm_host_model_i.read_byte(ADR_LANE_DIS, rdat, ok);
		check(rdat, 8'h05);
	endtask

	task automatic t_power();
		check({7'h0, high_power_en}, 8'h01);
		low_power_select = 1'b1;
		tick(6);
		check({7'h0, high_power_en}, 8'h00);
		wait_alert(20);
		qmm_host_model_i.read_byte(ADR_FLAGS, rdat, ok);
		check(rdat, 8'h02);
		check({7'h0, fault_alert_n}, 8'h01);
		low_power_select = 1'b0;
		tick(6);
		check({7'h0, high_power_en}, 8'h01);
		wait_alert(20);
		qmm_host_model_i.read_byte(ADR_FLAGS, rdat, ok);
		check(rdat, 8'h02);
		qmm_host_model_i.write_byte(ADR_CTRL, 8'h01, ok);
		tick(4);
		check({7'h0, high_power_en}, 8'h00);
		qmm_host_model_i.write_byte(ADR_CTRL, 8'h00, ok);
		tick(4);
		check({7'h0, high_power_en}, 8'h01);
		qmm_host_model_i.write_byte(ADR_CTRL, 8'h01, ok);
	endtask

	task automatic t_reset();
		module_reset_n = 1'b0;
		tick(100);
		check({3'h0, fault_alert_n, tx_lane_en}, 8'h1A);
		module_reset_n = 1'b1;
		tick(10);
		check({3'h0, fault_alert_n, tx_lane_en}, 8'h1A);
		module_reset_n = 1'b0;
		tick(450);
		check({3'h0, fault_alert_n, tx_lane_en}, 8'h10);
		module_reset_n = 1'b1;
		wait_alert(900);
		check({3'h0, high_power_en, tx_lane_en}, 8'h1F);
		qmm_host_model_i.read_byte(ADR_LANE_DIS, rdat, ok);
		check(rdat, {4'h0, LANE_DIS_RST});
		qmm_host_model_i.read_byte(ADR_CTRL, rdat, ok);
		check(rdat, {7'h0, CTRL_RST});
		qmm_host_model_i.read_byte(ADR_FLAGS, rdat, ok);
		check(rdat, 8'h01);
	endtask

	// =====================================================
	// main sequence
	initial
	begin
		sys_rst          = 1'b1;
		module_select_n  = 1'b0;
		module_reset_n   = 1'b1;
		low_power_select = 1'b0;
		tick(10);
		sys_rst = 1'b0;
		t_boot();
		t_lanes();
		t_select();
		t_power();
		t_reset();
		print_verdict();
	end
endmodule // qmm_top_bench
